//--- design/bcd2_step.v
// Two-digit BCD field that steps by one and wraps to a base value
`timescale 1ns/100ps
`default_nettype none

module bcd2_step (
  // Step request and limits
  input  wire       en,
  input  wire [7:0] val,
  input  wire [7:0] top,
  input  wire [7:0] base,
  // Next value and wrap carry
  output reg  [7:0] nxt,
  output reg        carry
);

  always @* begin
    carry = en & (val >= top);
    if (!en) begin
      nxt = val;
    end else if (val >= top) begin
      nxt = base;
    end else if (val[3:0] == 4'h9) begin
      nxt = {val[7:4] + 4'h1, 4'h0};
    end else begin
      nxt = {val[7:4], val[3:0] + 4'h1};
    end
  end

endmodule // bcd2_step

`default_nettype wire

//--- design/calendar_clock_tables.v
// Calendar clock with read-only value tables and write-only setting tables on AXI4-Lite
//
// Implementation choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "calendar_clock_defines.vh"

module calendar_clock_tables #(
  parameter [31:0] SEC_CYCLES = `CC_SEC_CYCLES
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // Write address channel
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [11:0] s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  // Write data channel
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  // Write response channel
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  output wire [1:0]  s_axi_bresp,
  // Read address channel
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  input  wire [11:0] s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  // Read data channel
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp
);

  localparam [25:0] SEC_LAST = SEC_CYCLES[25:0] - 26'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Byte address of a table index
  function [11:0] tbl_addr;
    input [7:0] idx;
    begin
      tbl_addr = {2'b00, idx, 2'b00};
    end
  endfunction

  // Both digits decimal and value within the limits
  function bcd_ok;
    input [7:0] v;
    input [7:0] lo;
    input [7:0] hi;
    begin
      bcd_ok = (v[3:0] <= 4'h9) && (v[7:4] <= 4'h9) && (v >= lo) && (v <= hi);
    end
  endfunction

  // Leap year on the last two BCD digits of the year
  function is_leap;
    input [7:0] y;
    begin
      if (!y[4]) begin
        is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
      end else begin
        is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
      end
    end
  endfunction

  // Last date of a month, in BCD
  function [7:0] last_date;
    input [7:0] m;
    input [7:0] y;
    begin
      case (m)
        `CC_FEBRUARY: last_date = is_leap(y) ? `CC_DAYS_29 : `CC_DAYS_28;
        8'h04, 8'h06, 8'h09, 8'h11: last_date = `CC_DAYS_30;
        default: last_date = `CC_MAX_DATE;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Time base

  reg  [25:0] prescale_ff;
  reg         sec_tick_ff;
  reg  [7:0]  second_ff;
  reg  [7:0]  minute_ff;
  reg  [7:0]  hour_ff;
  reg  [7:0]  date_ff;
  reg  [7:0]  month_ff;
  reg  [7:0]  year_ff;
  reg  [7:0]  weekday_ff;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      prescale_ff <= 26'h0;
      sec_tick_ff <= 1'b0;
    end else if (prescale_ff >= SEC_LAST) begin
      prescale_ff <= 26'h0;
      sec_tick_ff <= 1'b1;
    end else begin
      prescale_ff <= prescale_ff + 26'h1;
      sec_tick_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // BCD counting chain

  wire [7:0] step_sec;
  wire [7:0] step_min;
  wire [7:0] step_hour;
  wire [7:0] step_date;
  wire [7:0] step_month;
  wire [7:0] step_year;
  wire       c_sec;
  wire       c_min;
  wire       c_hour;
  wire       c_date;
  wire       c_month;
  wire [7:0] step_wday;

  bcd2_step u_sec (
    .en    (sec_tick_ff),
    .val   (second_ff),
    .top   (`CC_MAX_SECOND),
    .base  (`CC_ZERO),
    .nxt   (step_sec),
    .carry (c_sec)
  );

  bcd2_step u_min (
    .en    (c_sec),
    .val   (minute_ff),
    .top   (`CC_MAX_MINUTE),
    .base  (`CC_ZERO),
    .nxt   (step_min),
    .carry (c_min)
  );

  bcd2_step u_hour (
    .en    (c_min),
    .val   (hour_ff),
    .top   (`CC_MAX_HOUR),
    .base  (`CC_ZERO),
    .nxt   (step_hour),
    .carry (c_hour)
  );

  bcd2_step u_date (
    .en    (c_hour),
    .val   (date_ff),
    .top   (last_date(month_ff, year_ff)),
    .base  (`CC_MIN_DATE),
    .nxt   (step_date),
    .carry (c_date)
  );

  bcd2_step u_month (
    .en    (c_date),
    .val   (month_ff),
    .top   (`CC_MAX_MONTH),
    .base  (`CC_MIN_MONTH),
    .nxt   (step_month),
    .carry (c_month)
  );

  bcd2_step u_year (
    .en    (c_month),
    .val   (year_ff),
    .top   (`CC_MAX_YEAR),
    .base  (`CC_ZERO),
    .nxt   (step_year),
    .carry ()
  );

  // Weekday moves with each new day, Saturday back to Sunday
  assign step_wday = !c_hour ? weekday_ff :
                     (weekday_ff >= `CC_MAX_WEEKDAY) ? `CC_ZERO : weekday_ff + 8'h01;

  ////////////////////////////////////////////////////////////////////////////
  // Write channel

  reg         awready_ff;
  reg         wready_ff;
  reg         aw_got_ff;
  reg         w_got_ff;
  reg  [11:0] awaddr_ff;
  reg  [31:0] wdata_ff;
  reg  [3:0]  wstrb_ff;
  reg         bvalid_ff;
  reg  [1:0]  bresp_ff;

  reg         nxt_aw_got;
  reg         nxt_w_got;
  reg         nxt_bvalid;
  reg         do_write;
  reg         load_time;
  reg         load_myw;
  reg  [1:0]  nxt_bresp;

  wire [7:0]  set_sec   = wdata_ff[`CC_SET0_SEC_LSB +: 8];
  wire [7:0]  set_min   = wdata_ff[`CC_SET0_MIN_LSB +: 8];
  wire [7:0]  set_hour  = wdata_ff[`CC_SET0_HOUR_LSB +: 8];
  wire [7:0]  set_date  = wdata_ff[`CC_SET0_DATE_LSB +: 8];
  wire [7:0]  set_month = wdata_ff[`CC_SET1_MONTH_LSB +: 8];
  wire [7:0]  set_year  = wdata_ff[`CC_SET1_YEAR_LSB +: 8];
  wire [7:0]  set_wday  = wdata_ff[`CC_SET1_WDAY_LSB +: 8];
  wire [7:0]  set_vac   = wdata_ff[`CC_SET1_VACANT_LSB +: 8];

  // Settings are taken only whole and in range; anything else is refused
  wire time_ok = (wstrb_ff == 4'hf) &&
                 bcd_ok(set_sec, `CC_ZERO, `CC_MAX_SECOND) &&
                 bcd_ok(set_min, `CC_ZERO, `CC_MAX_MINUTE) &&
                 bcd_ok(set_hour, `CC_ZERO, `CC_MAX_HOUR) &&
                 bcd_ok(set_date, `CC_MIN_DATE, `CC_MAX_DATE);
  wire myw_ok  = (wstrb_ff == 4'hf) && (set_vac == `CC_ZERO) &&
                 bcd_ok(set_month, `CC_MIN_MONTH, `CC_MAX_MONTH) &&
                 bcd_ok(set_year, `CC_ZERO, `CC_MAX_YEAR) &&
                 bcd_ok(set_wday, `CC_ZERO, `CC_MAX_WEEKDAY);

  always @* begin
    nxt_aw_got = aw_got_ff | (s_axi_awvalid & awready_ff);
    nxt_w_got  = w_got_ff | (s_axi_wvalid & wready_ff);
    nxt_bvalid = bvalid_ff & ~s_axi_bready;
    nxt_bresp  = bresp_ff;
    do_write   = aw_got_ff & w_got_ff & ~bvalid_ff;
    load_time  = 1'b0;
    load_myw   = 1'b0;
    if (do_write) begin
      nxt_aw_got = 1'b0;
      nxt_w_got  = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp  = `CC_RESP_SLVERR;
      if (awaddr_ff == tbl_addr(`CC_IDX_SET_TIME)) begin
        load_time = time_ok;
        nxt_bresp = time_ok ? `CC_RESP_OKAY : `CC_RESP_SLVERR;
      end else if (awaddr_ff == tbl_addr(`CC_IDX_SET_MYW)) begin
        load_myw  = myw_ok;
        nxt_bresp = myw_ok ? `CC_RESP_OKAY : `CC_RESP_SLVERR;
      end
      // Current-time tables and unmapped words keep the error answer
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      aw_got_ff  <= 1'b0;
      w_got_ff   <= 1'b0;
      awaddr_ff  <= 12'h000;
      wdata_ff   <= 32'h00000000;
      wstrb_ff   <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `CC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && awready_ff) begin
        awaddr_ff <= {s_axi_awaddr[11:2], 2'b00};
      end
      if (s_axi_wvalid && wready_ff) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      aw_got_ff  <= nxt_aw_got;
      w_got_ff   <= nxt_w_got;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
      awready_ff <= ~nxt_aw_got & ~nxt_bvalid;
      wready_ff  <= ~nxt_w_got & ~nxt_bvalid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock registers; a loaded setting wins over the count in the same cycle

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      second_ff  <= `CC_RST_SECOND;
      minute_ff  <= `CC_RST_MINUTE;
      hour_ff    <= `CC_RST_HOUR;
      date_ff    <= `CC_RST_DATE;
      month_ff   <= `CC_RST_MONTH;
      year_ff    <= `CC_RST_YEAR;
      weekday_ff <= `CC_RST_WEEKDAY;
    end else begin
      if (load_time) begin
        second_ff <= set_sec;
        minute_ff <= set_min;
        hour_ff   <= set_hour;
        date_ff   <= set_date;
      end else begin
        second_ff <= step_sec;
        minute_ff <= step_min;
        hour_ff   <= step_hour;
        date_ff   <= step_date;
      end
      if (load_myw) begin
        month_ff   <= set_month;
        year_ff    <= set_year;
        weekday_ff <= set_wday;
      end else if (!load_time) begin
        month_ff   <= step_month;
        year_ff    <= step_year;
        weekday_ff <= step_wday;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel

  reg         arready_ff;
  reg         rvalid_ff;
  reg  [31:0] rdata_ff;
  reg  [1:0]  rresp_ff;
  reg  [7:0]  rd_byte;
  reg  [1:0]  rd_resp;

  wire [11:0] rd_addr = {s_axi_araddr[11:2], 2'b00};

  // Only the nine clock words answer; all else is an error
  always @* begin
    rd_byte = 8'h00;
    rd_resp = `CC_RESP_OKAY;
    if (rd_addr == tbl_addr(`CC_IDX_SECOND)) begin
      rd_byte = second_ff;
    end else if (rd_addr == tbl_addr(`CC_IDX_MINUTE)) begin
      rd_byte = minute_ff;
    end else if (rd_addr == tbl_addr(`CC_IDX_HOUR)) begin
      rd_byte = hour_ff;
    end else if (rd_addr == tbl_addr(`CC_IDX_DATE)) begin
      rd_byte = date_ff;
    end else if (rd_addr == tbl_addr(`CC_IDX_MONTH)) begin
      rd_byte = month_ff;
    end else if (rd_addr == tbl_addr(`CC_IDX_YEAR)) begin
      rd_byte = year_ff;
    end else if (rd_addr == tbl_addr(`CC_IDX_WEEKDAY)) begin
      rd_byte = weekday_ff;
    end else if ((rd_addr == tbl_addr(`CC_IDX_SET_TIME)) ||
                 (rd_addr == tbl_addr(`CC_IDX_SET_MYW))) begin
      rd_byte = 8'h00;
    end else begin
      rd_resp = `CC_RESP_SLVERR;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h00000000;
      rresp_ff   <= `CC_RESP_OKAY;
    end else if (s_axi_arvalid && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b1;
      rdata_ff   <= {24'h000000, rd_byte};
      rresp_ff   <= rd_resp;
    end else if (rvalid_ff) begin
      rvalid_ff  <= ~s_axi_rready;
      arready_ff <= s_axi_rready;
    end else begin
      arready_ff <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

endmodule // calendar_clock_tables

`default_nettype wire

//--- dv/calendar_clock_tables_props.sv
// Checker of bus answers and table values of the calendar clock tables
`timescale 1ns/100ps
`default_nettype none
`include "calendar_clock_defines.vh"

module calendar_clock_tables_props (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Write channels
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  // Read channels
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////////
  ro_reject_a: assert property ($rose(s_axi_bvalid) && $past(s_axi_awaddr[11:2], 2) <= `CC_IDX_WEEKDAY
    |-> s_axi_bresp == `CC_RESP_SLVERR) else $error("write below setting tables not refused");
  set_read_zero_a: assert property ($rose(s_axi_rvalid) && $past(s_axi_araddr[11:3]) == 9'h07f
    |-> s_axi_rdata == 32'h0 && s_axi_rresp == `CC_RESP_OKAY) else $error("setting table read not zero");
  upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bytes not zero");
  bcd_digits_a: assert property (s_axi_rvalid |-> s_axi_rdata[3:0] <= 4'h9 && s_axi_rdata[7:4] <= 4'h9)
    else $error("read value not two BCD digits");
  sec_range_a: assert property ($rose(s_axi_rvalid) && $past(s_axi_araddr[11:2]) == `CC_IDX_SECOND
    |-> s_axi_rdata[7:0] <= 8'h59) else $error("second out of range");
  hour_range_a: assert property ($rose(s_axi_rvalid) && $past(s_axi_araddr[11:2]) == `CC_IDX_HOUR
    |-> s_axi_rdata[7:0] <= 8'h23) else $error("hour out of range");
  wday_range_a: assert property ($rose(s_axi_rvalid) && $past(s_axi_araddr[11:2]) == `CC_IDX_WEEKDAY
    |-> s_axi_rdata[7:0] <= 8'h06) else $error("weekday out of range");
  w_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write answer late");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");

  cover property ($rose(s_axi_bvalid) && s_axi_bresp == `CC_RESP_OKAY);
  cover property ($rose(s_axi_bvalid) && s_axi_bresp == `CC_RESP_SLVERR);
  cover property (s_axi_rvalid && s_axi_rresp == `CC_RESP_SLVERR);
endmodule // calendar_clock_tables_props

bind calendar_clock_tables calendar_clock_tables_props u_calendar_clock_tables_props (
  .clk(clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp));
`default_nettype wire

//--- dv/cc_host.sv
// Host controller model: AXI4-Lite master reaching the clock tables
`timescale 1ns/100ps
`default_nettype none

module cc_host (
  // Clock
  input  wire logic        clk,
  // Write channels
  output var  logic        awvalid,
  input  wire logic        awready,
  output var  logic [11:0] awaddr,
  output var  logic        wvalid,
  input  wire logic        wready,
  output var  logic [31:0] wdata,
  output var  logic [3:0]  wstrb,
  input  wire logic        bvalid,
  output var  logic        bready,
  input  wire logic [1:0]  bresp,
  // Read channels
  output var  logic        arvalid,
  input  wire logic        arready,
  output var  logic [11:0] araddr,
  input  wire logic        rvalid,
  output var  logic        rready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  // Waits that ran out
  output var  int          hangs
);
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, wstrb} = 60'h0;
    hangs = 0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Answer readiness is raised after lag cycles to model a slow host
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input int lag,
                    output logic [1:0] r);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= (lag == 0);
    for (n = 0; n < 64; n++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
      if (n + 1 >= lag) bready <= 1'b1;
    end
    r = bresp;
    bready <= 1'b0;
    if (n == 64) hangs++;
  endtask

  task automatic rd(input logic [11:0] a, input int lag, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= (lag == 0);
    for (n = 0; n < 64; n++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
      if (n + 1 >= lag) rready <= 1'b1;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n == 64) hangs++;
  endtask
endmodule // cc_host
`default_nettype wire

//--- dv/testbench.sv
// Self-checking bench of the calendar clock tables
`timescale 1ns/100ps
`default_nettype none
`include "calendar_clock_defines.vh"

module testbench;
  localparam int SEC = 400;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  int          fails = 0;
  int          num_checks = 0;
  int          hangs;
  int          seed = 33644;

  always #12.5 clk = ~clk;

  calendar_clock_tables #(.SEC_CYCLES(SEC)) u_calendar_clock_tables (
    .clk(clk), .rst(rst),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp));

  cc_host u_cc_host (
    .clk(clk), .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .hangs(hangs));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    fails += hangs;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  function automatic int rnd(input int n);
    return $unsigned($random(seed)) % n;
  endfunction
  function automatic logic [7:0] i2b(input int i);
    return {4'(i / 10), 4'(i % 10)};
  endfunction
  function automatic int mdays(input int m, input int y);
    if (m == 2) return (y % 4 == 0) ? 29 : 28;
    if (m == 4 || m == 6 || m == 9 || m == 11) return 30;
    return 31;
  endfunction

  task automatic put(input int idx, input logic [31:0] d, input logic [3:0] s, input logic [1:0] e);
    logic [1:0] r;
    u_cc_host.wr(12'(idx * 4), d, s, rnd(3), r);
    chk(r, e);
    if (hangs > 0) final_report();
  endtask
  task automatic get(input int idx, input logic [1:0] e, output logic [31:0] d);
    logic [1:0] r;
    u_cc_host.rd(12'(idx * 4), rnd(3), d, r);
    chk(r, e);
    if (hangs > 0) final_report();
  endtask
  task automatic rd_all(output logic [7:0] t[7]);
    logic [31:0] d;
    for (int i = 0; i < 7; i++) begin
      get(`CC_IDX_SECOND + i, `CC_RESP_OKAY, d);
      t[i] = d[7:0];
    end
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    fails++;
    final_report();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0]  t[7];
    logic [7:0]  e[7];
    logic [31:0] d;
    int s, mi, h, dt, mo, yr, wd, n, nd, nm, ny;
    static int cd[8] = '{31, 28, 28, 29, 30, 30, 31, 0};
    static int cm[8] = '{12, 2, 2, 2, 4, 11, 1, 0};
    static int cy[8] = '{99, 23, 24, 24, 10, 5, 50, 0};
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    // Time after reset
    rd_all(t);
    e = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00};
    for (int i = 0; i < 7; i++) chk(t[i], e[i]);
    $display("test reset values done");
    // Refused writes and reads, and zero reads of the setting tables
    for (int i = `CC_IDX_SECOND; i <= `CC_IDX_WEEKDAY; i++) put(i, 32'h1, 4'hf, `CC_RESP_SLVERR);
    put(100, 32'h1, 4'hf, `CC_RESP_SLVERR);
    get(100, `CC_RESP_SLVERR, d);
    chk(d, 32'h0);
    get(`CC_IDX_SET_TIME, `CC_RESP_OKAY, d);
    chk(d, 32'h0);
    get(`CC_IDX_SET_MYW, `CC_RESP_OKAY, d);
    chk(d, 32'h0);
    put(`CC_IDX_SET_TIME, 32'h01000060, 4'hf, `CC_RESP_SLVERR);
    put(`CC_IDX_SET_TIME, 32'h01240000, 4'hf, `CC_RESP_SLVERR);
    put(`CC_IDX_SET_TIME, 32'h0100001a, 4'hf, `CC_RESP_SLVERR);
    put(`CC_IDX_SET_TIME, 32'h01000000, 4'h7, `CC_RESP_SLVERR);
    put(`CC_IDX_SET_MYW, 32'h01000001, 4'hf, `CC_RESP_SLVERR);
    put(`CC_IDX_SET_MYW, 32'h00070001, 4'hf, `CC_RESP_SLVERR);
    put(`CC_IDX_SET_MYW, 32'h00000013, 4'hf, `CC_RESP_SLVERR);
    rd_all(t);
    for (int i = 1; i < 7; i++) chk(t[i], e[i]);
    $display("test refusals done");
    // Random settings, with the host pausing between the two tables
    for (int c = 0; c < 4; c++) begin
      s = rnd(58); mi = rnd(60); h = rnd(24); dt = 1 + rnd(28);
      mo = 1 + rnd(12); yr = rnd(100); wd = rnd(7);
      put(`CC_IDX_SET_TIME, {i2b(dt), i2b(h), i2b(mi), i2b(s)}, 4'hf, `CC_RESP_OKAY);
      repeat (SEC - 60) @(posedge clk);
      put(`CC_IDX_SET_MYW, {8'h00, i2b(wd), i2b(yr), i2b(mo)}, 4'hf, `CC_RESP_OKAY);
      rd_all(t);
      chk(t[0], (t[0] === i2b(s + 1)) ? i2b(s + 1) : i2b(s));
      e = '{8'h00, i2b(mi), i2b(h), i2b(dt), i2b(mo), i2b(yr), i2b(wd)};
      for (int i = 1; i < 7; i++) chk(t[i], e[i]);
    end
    $display("test settings done");
    // Day rollover at month, leap and year ends, every weekday code
    for (int c = 0; c < 8; c++) begin
      dt = (c == 7) ? 1 + rnd(27) : cd[c];
      mo = (c == 7) ? 1 + rnd(12) : cm[c];
      yr = (c == 7) ? rnd(100) : cy[c];
      put(`CC_IDX_SET_MYW, {8'h00, i2b(c % 7), i2b(yr), i2b(mo)}, 4'hf, `CC_RESP_OKAY);
      put(`CC_IDX_SET_TIME, {i2b(dt), 24'h235959}, 4'hf, `CC_RESP_OKAY);
      n = 0;
      do begin
        get(`CC_IDX_SECOND, `CC_RESP_OKAY, d);
        n++;
      end while (d[7:0] !== 8'h00 && n < SEC);
      if (n == SEC) begin
        fails++;
        final_report();
      end
      nd = dt + 1; nm = mo; ny = yr;
      if (nd > mdays(mo, yr)) begin
        nd = 1;
        nm = mo + 1;
      end
      if (nm > 12) begin
        nm = 1;
        ny = (yr + 1) % 100;
      end
      rd_all(t);
      e = '{8'h00, 8'h00, 8'h00, i2b(nd), i2b(nm), i2b(ny), i2b((c + 1) % 7)};
      for (int i = 1; i < 7; i++) chk(t[i], e[i]);
    end
    $display("test rollover done");
    final_report();
  end
endmodule // testbench
`default_nettype wire

//--- include/calendar_clock_defines.vh
// Constants of the calendar clock tables: indexes, fields, reset values, timing
`ifndef CALENDAR_CLOCK_DEFINES_VH
`define CALENDAR_CLOCK_DEFINES_VH

// Table indexes 247 to 255 decimal; the byte address of a table is four times its index
`define CC_IDX_SECOND      8'hf7
`define CC_IDX_MINUTE      8'hf8
`define CC_IDX_HOUR        8'hf9
`define CC_IDX_DATE        8'hfa
`define CC_IDX_MONTH       8'hfb
`define CC_IDX_YEAR        8'hfc
`define CC_IDX_WEEKDAY     8'hfd
`define CC_IDX_SET_TIME    8'hfe
`define CC_IDX_SET_MYW     8'hff
`define CC_IDX_FIRST       8'hf7
`define CC_ADDR_W          12

// Field positions in the first setting table
`define CC_SET0_SEC_LSB    0
`define CC_SET0_MIN_LSB    8
`define CC_SET0_HOUR_LSB   16
`define CC_SET0_DATE_LSB   24
// Field positions in the second setting table
`define CC_SET1_MONTH_LSB  0
`define CC_SET1_YEAR_LSB   8
`define CC_SET1_WDAY_LSB   16
`define CC_SET1_VACANT_LSB 24

// Field limits, two BCD digits each
`define CC_MAX_SECOND      8'h59
`define CC_MAX_MINUTE      8'h59
`define CC_MAX_HOUR        8'h23
`define CC_MIN_DATE        8'h01
`define CC_MAX_DATE        8'h31
`define CC_MIN_MONTH       8'h01
`define CC_MAX_MONTH       8'h12
`define CC_MAX_YEAR        8'h99
`define CC_MAX_WEEKDAY     8'h06
`define CC_ZERO            8'h00
`define CC_DAYS_30         8'h30
`define CC_DAYS_29         8'h29
`define CC_DAYS_28         8'h28
`define CC_FEBRUARY        8'h02

// Values after reset: 00:00:00, date 01, month 01, year 00, Sunday
`define CC_RST_SECOND      8'h00
`define CC_RST_MINUTE      8'h00
`define CC_RST_HOUR        8'h00
`define CC_RST_DATE        8'h01
`define CC_RST_MONTH       8'h01
`define CC_RST_YEAR        8'h00
`define CC_RST_WEEKDAY     8'h00

// One second of the clock, in cycles of the 25 ns system clock
`define CC_SECOND_NS       1000000000
`define CC_CLK_NS          25
`define CC_SEC_CYCLES      (`CC_SECOND_NS / `CC_CLK_NS)

// AXI responses
`define CC_RESP_OKAY       2'b00
`define CC_RESP_SLVERR     2'b10

`endif
